// ### pgc_chk.sv
// Port checker for pgc_top.
// Assumes the default gap of 12 and eight preamble bytes.
`default_nettype none
module pgc_chk #(
    parameter int PRE_BYTES = 8
) (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic [4:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [7:0]  gen_txd_o,
    input wire logic        gen_tx_en_o,
    input wire logic        gen_tx_er_o,
    input wire logic        stub_test_o
);
    logic [10:0] hi_q;
    logic [10:0] lo_q;
    logic        seen_q;
    // Cycle counts since the frame valid last changed
    always_ff @(posedge mclk_i) begin
        hi_q   <= (rst_i || !gen_tx_en_o) ? 11'h000 : hi_q + 11'h001;
        lo_q   <= (rst_i || gen_tx_en_o) ? 11'h000 : lo_q + 11'h001;
        seen_q <= !rst_i && (seen_q || gen_tx_en_o);
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_pre;
        (gen_txd_o == 8'h55) [*7] ##1 (gen_txd_o == 8'hD5);
    endsequence
    a_frame_len: assert property ($fell(gen_tx_en_o) |-> (hi_q == 11'h048 || hi_q == 11'h5F6))
        else $error("frame length wrong");
    a_gap_min: assert property ($rose(gen_tx_en_o) && seen_q |-> lo_q >= 11'h00D)
        else $error("gap too short");
    a_pre_order: assert property ($rose(gen_tx_en_o) |-> s_pre)
        else $error("preamble wrong");
    a_err_place: assert property (gen_tx_er_o |-> gen_tx_en_o && (hi_q == 11'h044 || hi_q == 11'h5F2))
        else $error("symbol error misplaced");
    a_err_pulse: assert property (gen_tx_er_o |=> !gen_tx_er_o)
        else $error("symbol error too long");
    a_stub_copy: assert property (reg_wr_i && reg_addr_i == 5'h12 |=> ##1 stub_test_o == $past(reg_wdata_i[3], 2))
        else $error("stub mode wrong");
    a_lc_clear: assert property (reg_rd_i && reg_addr_i == 5'h17 ##2 reg_rd_i && reg_addr_i == 5'h17
        |=> reg_rdata_o[15:8] <= 8'h01 && reg_rdata_o[7:0] <= 8'h01)
        else $error("late count not cleared");
    a_cnt_clear: assert property (reg_wr_i && reg_addr_i == 5'h12 && reg_wdata_i[4] ##2 reg_rd_i
        && reg_addr_i == 5'h11 |=> reg_rdata_o[15:8] <= 8'h01 && reg_rdata_o[7:0] <= 8'h01)
        else $error("counts not cleared");
endmodule
`default_nettype wire

// ### pgc_crc32_step.sv
// One byte step of the reflected Ethernet CRC-32.
// Purely combinational; caller holds the running value.

`default_nettype none

module pgc_crc32_step (
    // Running value and byte
    input  wire logic [31:0] crc_i,
    input  wire logic [7:0]  data_i,
    // Updated value
    output logic      [31:0] crc_o
);

    logic [31:0] c;

    always_comb begin
        c = crc_i;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data_i[i]) begin
                c = {1'b0, c[31:1]} ^ 32'hEDB88320;
            end else begin
                c = {1'b0, c[31:1]};
            end
        end
        crc_o = c;
    end

endmodule

`default_nettype wire

// ### pgc_partner.sv
// Link partner: loops the generated stream back or sends a frame with no SFD.
// Assumes the block's byte clock; kick_i is a one-cycle request.
`default_nettype none
module pgc_partner (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench control
    input  wire logic       loop_i,
    input  wire logic       kick_i,
    // From the block
    input  wire logic [7:0] txd_i,
    input  wire logic       tx_en_i,
    input  wire logic       tx_er_i,
    // To the block
    output logic      [7:0] rxd_o,
    output logic            rx_dv_o,
    output logic            rx_er_o
);
    logic [3:0] left_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_q  <= 4'h0;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            rxd_o   <= 8'h00;
        end else begin
            left_q  <= kick_i ? 4'hF : left_q - {3'h0, left_q != 4'h0};
            rx_dv_o <= loop_i ? tx_en_i : left_q != 4'h0;
            rx_er_o <= loop_i && tx_er_i;
            // Idle byte toggles so a stale value never looks valid
            rxd_o   <= (loop_i && tx_en_i) ? txd_i : ~rxd_o;
        end
    end
endmodule
`default_nettype wire

// ### pgc_pkg.sv
// Constants and types shared by the packet generator / checker test block.
// Assumes a single byte clock and a plain 16-bit register port.
//
// How it works
// (RULE1) Burst field zero sends forever; 1..255 sends that many then stops.
// (RULE2) Trigger bit acts only with keep-enable, generator enable and nonzero burst.
// (RULE3) Trigger bit reads 1 when burst finished, 0 while transmitting.
// (RULE4) Writing 0 to a set done bit restarts the burst; otherwise ignored.
// (RULE5) Without keep-enable the enable bit clears itself after the burst.
// (RULE6) Payload select: 0 pseudo-random, 1 repeating 5A/A5 bytes.
// (RULE7) Length select: 1 gives 1518-byte packets, 0 gives 64-byte packets.
// (RULE8) Error injection sends bad CRC plus a symbol error; otherwise clean.
// (RULE9) Received-packet counter is eight bits and saturates at FF.
// (RULE10) CRC-error counter counts failed packets and saturates at FF.
// (RULE11) Checker counters only valid and counting while checker enabled.
// (RULE12) Writing 1 to counter reset zeroes counters, bit self-clears.
// (RULE13) Stub-test bit selects stub test mode when set.
// (RULE14) Gap between generated packets lasts field plus one bytes; resets to 12.
// (RULE15) Half duplex: rx start during tx bytes 97..128 bumps first counter.
// (RULE16) Half duplex: rx start during tx bytes 65..96 bumps second counter.
// (RULE17) Late-collision counters saturate and clear when read.
// (RULE18) Byte positions counted on the internal byte interface.
// (RULE19) Clean generated packets carry a correct frame check sequence.

`default_nettype none

package pgc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [4:0] OFS_GEN_CTRL   = 5'h10;
    localparam logic [4:0] OFS_CHK_COUNTS = 5'h11;
    localparam logic [4:0] OFS_CHK_CTRL   = 5'h12;
    localparam logic [4:0] OFS_GAP_LEN    = 5'h13;
    localparam logic [4:0] OFS_LATE_COLL  = 5'h17;

    // ==========================================================
    // Field positions
    localparam int BIT_BURST_LSB = 8;
    localparam int BIT_TRIGGER   = 7;
    localparam int BIT_KEEP_EN   = 6;
    localparam int BIT_CHK_EN    = 4;
    localparam int BIT_GEN_EN    = 3;
    localparam int BIT_PATTERN   = 2;
    localparam int BIT_LONG      = 1;
    localparam int BIT_ERR_INJ   = 0;
    localparam int BIT_CNT_CLR   = 4;
    localparam int BIT_STUB      = 3;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_GEN_CTRL = 16'h0000;
    localparam logic [15:0] RST_CHK_CTRL = 16'h0000;
    localparam logic [15:0] RST_GAP_LEN  = 16'h000C;
    localparam logic [15:0] RST_LFSR     = 16'hACE1;

    // ==========================================================
    // Frame layout and timing counts, in bytes
    localparam logic [10:0] LEN_SHORT   = 11'h040;
    localparam logic [10:0] LEN_LONG    = 11'h5EE;
    localparam logic [10:0] FCS_BYTES   = 11'h004;
    localparam logic [10:0] LC1_FIRST   = 11'h061;
    localparam logic [10:0] LC1_LAST    = 11'h080;
    localparam logic [10:0] LC2_FIRST   = 11'h041;
    localparam logic [10:0] LC2_LAST    = 11'h060;
    localparam logic [7:0]  BYTE_PRE    = 8'h55;
    localparam logic [7:0]  BYTE_SFD    = 8'hD5;
    localparam logic [7:0]  BYTE_PAT_A  = 8'h5A;
    localparam logic [7:0]  BYTE_PAT_B  = 8'hA5;
    localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

    // ==========================================================
    // Generator states
    typedef enum logic [4:0] {
        GEN_IDLE = 5'b00001,
        GEN_PRE  = 5'b00010,
        GEN_DATA = 5'b00100,
        GEN_FCS  = 5'b01000,
        GEN_GAP  = 5'b10000
    } pgc_gen_e;

endpackage

`default_nettype wire

// ### pgc_top.sv
// Packet generator, CRC checker and late-collision counters of the copper port test logic.
// Assumes internal byte-interface signals on the same clock and a one-cycle register port.
//
// Decided for this implementation: strobed register access.

`default_nettype none

module pgc_top #(
    parameter int PRE_BYTES = 8
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // Generated transmit stream
    output logic      [7:0]  gen_txd_o,
    output logic             gen_tx_en_o,
    output logic             gen_tx_er_o,
    // Observed traffic
    input  wire logic        mac_tx_en_i,
    input  wire logic [7:0]  rxd_i,
    input  wire logic        rx_dv_i,
    input  wire logic        rx_er_i,
    input  wire logic        half_duplex_i,
    // Mode outputs
    output logic             stub_test_o
);

    // ==========================================================
    // Elaboration check
    if (PRE_BYTES < 2 || PRE_BYTES > 16) begin : g_bad_pre
        $error("PRE_BYTES must lie between 2 and 16");
    end

    localparam logic [10:0] PRE_LAST = 11'(PRE_BYTES - 1);

    // ==========================================================
    // Helpers
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    function automatic logic in_range(input logic [10:0] p,
                                      input logic [10:0] lo,
                                      input logic [10:0] hi);
        in_range = (p >= lo) && (p <= hi);
    endfunction

    // ==========================================================
    // Register storage
    logic [7:0]  burst_q;
    logic        keep_q;
    logic        rsv5_q;
    logic        chk_en_q;
    logic        gen_en_q;
    logic        pattern_q;
    logic        long_q;
    logic        err_inj_q;
    logic [15:0] chk_ctl_q;
    logic        cnt_clr_q;
    logic [15:0] gap_q;
    logic        start_q;

    // Generator state
    pgc_pkg::pgc_gen_e state_q;
    logic [10:0] cnt_q;
    logic [7:0]  left_q;
    logic        pend_q;
    logic        done_q;
    logic        burst_end_q;
    logic [31:0] tx_crc_q;
    logic [15:0] lfsr_q;
    logic        pat_phase_q;

    // Checker state
    logic        rx_dv_prev_q;
    logic        sfd_seen_q;
    logic        rx_bad_q;
    logic [31:0] rx_crc_q;
    logic [7:0]  pkt_cnt_q;
    logic [7:0]  crc_err_q;

    // Late-collision state
    logic [10:0] tx_pos_q;
    logic [7:0]  lc_97_q;
    logic [7:0]  lc_65_q;

    logic        wr_gen;
    logic        wr_chk;
    logic        rd_lc;
    logic        trig_valid;
    logic [7:0]  payload;
    logic [31:0] tx_crc_next;
    logic [31:0] rx_crc_next;
    logic [10:0] data_last;
    logic        last_pkt;

    assign wr_gen = reg_wr_i && (reg_addr_i == pgc_pkg::OFS_GEN_CTRL);
    assign wr_chk = reg_wr_i && (reg_addr_i == pgc_pkg::OFS_CHK_CTRL);
    assign rd_lc  = reg_rd_i && (reg_addr_i == pgc_pkg::OFS_LATE_COLL);

    // (RULE2) trigger validity gate
    assign trig_valid = keep_q && gen_en_q && (burst_q != 8'h00);

    // ==========================================================
    // Register writes
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            burst_q   <= pgc_pkg::RST_GEN_CTRL[15:8];
            keep_q    <= pgc_pkg::RST_GEN_CTRL[pgc_pkg::BIT_KEEP_EN];
            rsv5_q    <= pgc_pkg::RST_GEN_CTRL[5];
            chk_en_q  <= pgc_pkg::RST_GEN_CTRL[pgc_pkg::BIT_CHK_EN];
            gen_en_q  <= pgc_pkg::RST_GEN_CTRL[pgc_pkg::BIT_GEN_EN];
            pattern_q <= pgc_pkg::RST_GEN_CTRL[pgc_pkg::BIT_PATTERN];
            long_q    <= pgc_pkg::RST_GEN_CTRL[pgc_pkg::BIT_LONG];
            err_inj_q <= pgc_pkg::RST_GEN_CTRL[pgc_pkg::BIT_ERR_INJ];
            start_q   <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_gen) begin
                burst_q   <= reg_wdata_i[15:8];
                keep_q    <= reg_wdata_i[pgc_pkg::BIT_KEEP_EN];
                rsv5_q    <= reg_wdata_i[5];
                chk_en_q  <= reg_wdata_i[pgc_pkg::BIT_CHK_EN];
                gen_en_q  <= reg_wdata_i[pgc_pkg::BIT_GEN_EN];
                pattern_q <= reg_wdata_i[pgc_pkg::BIT_PATTERN];
                long_q    <= reg_wdata_i[pgc_pkg::BIT_LONG];
                err_inj_q <= reg_wdata_i[pgc_pkg::BIT_ERR_INJ];
                // Enable going high starts a burst
                if (reg_wdata_i[pgc_pkg::BIT_GEN_EN] && !gen_en_q) begin
                    start_q <= 1'b1;
                end
                // (RULE4) zero written to a set done bit retriggers
                if (trig_valid && done_q && !reg_wdata_i[pgc_pkg::BIT_TRIGGER]
                    && reg_wdata_i[pgc_pkg::BIT_GEN_EN]) begin
                    start_q <= 1'b1;
                end
            end else if (burst_end_q && !keep_q) begin
                // (RULE5) enable self-clears
                gen_en_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            chk_ctl_q <= pgc_pkg::RST_CHK_CTRL;
            cnt_clr_q <= 1'b0;
            gap_q     <= pgc_pkg::RST_GAP_LEN;
        end else begin
            // (RULE12) counter reset pulse self-clears
            cnt_clr_q <= wr_chk && reg_wdata_i[pgc_pkg::BIT_CNT_CLR];
            if (wr_chk) begin
                chk_ctl_q <= reg_wdata_i;
            end
            if (reg_wr_i && (reg_addr_i == pgc_pkg::OFS_GAP_LEN)) begin
                gap_q <= reg_wdata_i;
            end
        end
    end

    // (RULE13) stub test mode
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stub_test_o <= 1'b0;
        end else begin
            stub_test_o <= chk_ctl_q[pgc_pkg::BIT_STUB];
        end
    end

    // ==========================================================
    // Register reads, data valid in the following cycle only
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_addr_i == pgc_pkg::OFS_GEN_CTRL) begin
            // (RULE3) trigger bit reads the done flag
            reg_rdata_o <= {burst_q, done_q, keep_q, rsv5_q, chk_en_q,
                            gen_en_q, pattern_q, long_q, err_inj_q};
        end else if (reg_addr_i == pgc_pkg::OFS_CHK_COUNTS) begin
            reg_rdata_o <= {pkt_cnt_q, crc_err_q};
        end else if (reg_addr_i == pgc_pkg::OFS_CHK_CTRL) begin
            reg_rdata_o <= {chk_ctl_q[15:5], cnt_clr_q, chk_ctl_q[3:0]};
        end else if (reg_addr_i == pgc_pkg::OFS_GAP_LEN) begin
            reg_rdata_o <= gap_q;
        end else if (reg_addr_i == pgc_pkg::OFS_LATE_COLL) begin
            reg_rdata_o <= {lc_97_q, lc_65_q};
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ==========================================================
    // Generator payload and CRC
    // (RULE6) payload source
    assign payload = pattern_q ? (pat_phase_q ? pgc_pkg::BYTE_PAT_B : pgc_pkg::BYTE_PAT_A)
                               : lfsr_q[7:0];

    // (RULE7) data bytes end four before the frame length
    assign data_last = (long_q ? pgc_pkg::LEN_LONG : pgc_pkg::LEN_SHORT)
                       - pgc_pkg::FCS_BYTES - 11'h001;

    // (RULE1) stop after the burst unless continuous
    assign last_pkt = !gen_en_q || ((burst_q != 8'h00) && (left_q <= 8'h01));

    pgc_crc32_step u_tx_crc (
        .crc_i  (tx_crc_q),
        .data_i (payload),
        .crc_o  (tx_crc_next)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lfsr_q <= pgc_pkg::RST_LFSR;
        end else if (state_q == pgc_pkg::GEN_DATA) begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    // ==========================================================
    // Generator sequencing
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_q     <= pgc_pkg::GEN_IDLE;
            cnt_q       <= 11'h000;
            left_q      <= 8'h00;
            pend_q      <= 1'b0;
            done_q      <= 1'b0;
            burst_end_q <= 1'b0;
            tx_crc_q    <= pgc_pkg::CRC_INIT;
            pat_phase_q <= 1'b0;
            gen_txd_o   <= 8'h00;
            gen_tx_en_o <= 1'b0;
            gen_tx_er_o <= 1'b0;
        end else begin
            burst_end_q <= 1'b0;
            gen_tx_er_o <= 1'b0;
            if (start_q) begin
                pend_q <= 1'b1;
                // Pending burst must not read as done
                done_q <= 1'b0;
            end
            case (state_q)
                pgc_pkg::GEN_IDLE: begin
                    gen_tx_en_o <= 1'b0;
                    gen_txd_o   <= 8'h00;
                    if (pend_q && gen_en_q) begin
                        pend_q      <= start_q;
                        left_q      <= burst_q;
                        done_q      <= 1'b0;
                        state_q     <= pgc_pkg::GEN_PRE;
                        cnt_q       <= 11'h001;
                        gen_tx_en_o <= 1'b1;
                        gen_txd_o   <= pgc_pkg::BYTE_PRE;
                    end
                end
                pgc_pkg::GEN_PRE: begin
                    cnt_q <= cnt_q + 11'h001;
                    if (cnt_q == PRE_LAST) begin
                        gen_txd_o   <= pgc_pkg::BYTE_SFD;
                        state_q     <= pgc_pkg::GEN_DATA;
                        cnt_q       <= 11'h000;
                        tx_crc_q    <= pgc_pkg::CRC_INIT;
                        pat_phase_q <= 1'b0;
                    end else begin
                        gen_txd_o <= pgc_pkg::BYTE_PRE;
                    end
                end
                pgc_pkg::GEN_DATA: begin
                    gen_txd_o   <= payload;
                    pat_phase_q <= !pat_phase_q;
                    // (RULE19) running FCS over the payload
                    tx_crc_q    <= tx_crc_next;
                    cnt_q       <= cnt_q + 11'h001;
                    if (cnt_q == data_last) begin
                        state_q <= pgc_pkg::GEN_FCS;
                        cnt_q   <= 11'h000;
                    end
                end
                pgc_pkg::GEN_FCS: begin
                    // (RULE8) uncomplemented FCS and a symbol error when injecting
                    if (err_inj_q) begin
                        gen_txd_o   <= tx_crc_q[{cnt_q[1:0], 3'b000} +: 8];
                        gen_tx_er_o <= (cnt_q == 11'h000);
                    end else begin
                        gen_txd_o <= ~tx_crc_q[{cnt_q[1:0], 3'b000} +: 8];
                    end
                    cnt_q <= cnt_q + 11'h001;
                    if (cnt_q == pgc_pkg::FCS_BYTES - 11'h001) begin
                        state_q <= pgc_pkg::GEN_GAP;
                        cnt_q   <= 11'h000;
                    end
                end
                pgc_pkg::GEN_GAP: begin
                    gen_tx_en_o <= 1'b0;
                    gen_txd_o   <= 8'h00;
                    cnt_q       <= cnt_q + 11'h001;
                    // (RULE14) gap of field plus one bytes
                    if (cnt_q == {3'b000, gap_q[7:0]} + 11'h001) begin
                        if (last_pkt) begin
                            // (RULE3) done once the burst is out
                            done_q      <= 1'b1;
                            burst_end_q <= 1'b1;
                            state_q     <= pgc_pkg::GEN_IDLE;
                        end else begin
                            left_q      <= left_q - 8'h01;
                            state_q     <= pgc_pkg::GEN_PRE;
                            cnt_q       <= 11'h001;
                            gen_tx_en_o <= 1'b1;
                            gen_txd_o   <= pgc_pkg::BYTE_PRE;
                        end
                    end
                end
                default: begin
                    state_q <= pgc_pkg::GEN_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // CRC checker
    pgc_crc32_step u_rx_crc (
        .crc_i  (rx_crc_q),
        .data_i (rxd_i),
        .crc_o  (rx_crc_next)
    );

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rx_dv_prev_q <= 1'b0;
            sfd_seen_q   <= 1'b0;
            rx_bad_q     <= 1'b0;
            rx_crc_q     <= pgc_pkg::CRC_INIT;
        end else begin
            rx_dv_prev_q <= rx_dv_i;
            if (rx_dv_i) begin
                if (!sfd_seen_q) begin
                    sfd_seen_q <= (rxd_i == pgc_pkg::BYTE_SFD);
                    rx_crc_q   <= pgc_pkg::CRC_INIT;
                end else begin
                    rx_crc_q <= rx_crc_next;
                end
                if (rx_er_i) begin
                    rx_bad_q <= 1'b1;
                end
            end else begin
                sfd_seen_q <= 1'b0;
                rx_bad_q   <= 1'b0;
            end
        end
    end

    // Counter reset yields to a packet ending in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pkt_cnt_q <= 8'h00;
            crc_err_q <= 8'h00;
        end else begin
            // (RULE12) clear, then let a simultaneous count land
            if (cnt_clr_q) begin
                pkt_cnt_q <= 8'h00;
                crc_err_q <= 8'h00;
            end
            // (RULE11) counts only while the checker is enabled
            if (chk_en_q && rx_dv_prev_q && !rx_dv_i && sfd_seen_q) begin
                // (RULE9) saturating packet count
                pkt_cnt_q <= sat_inc(cnt_clr_q ? 8'h00 : pkt_cnt_q);
                // (RULE10) saturating CRC error count
                if (rx_bad_q || (rx_crc_q != pgc_pkg::CRC_RESIDUE)) begin
                    crc_err_q <= sat_inc(cnt_clr_q ? 8'h00 : crc_err_q);
                end
            end
        end
    end

    // ==========================================================
    // Late-collision window
    logic tx_seen;
    logic rx_sop;

    // (RULE18) positions taken from the internal byte interface
    assign tx_seen = gen_tx_en_o || mac_tx_en_i;
    assign rx_sop  = rx_dv_i && !rx_dv_prev_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tx_pos_q <= 11'h000;
        end else if (!tx_seen) begin
            tx_pos_q <= 11'h000;
        end else if (tx_pos_q != 11'h7FF) begin
            tx_pos_q <= tx_pos_q + 11'h001;
        end
    end

    // Byte now on the interface is tx_pos_q + 1
    logic [10:0] cur_byte;
    logic        hit_97;
    logic        hit_65;

    assign cur_byte = (tx_pos_q == 11'h7FF) ? tx_pos_q : tx_pos_q + 11'h001;
    // (RULE15) window 97..128
    assign hit_97 = half_duplex_i && tx_seen && rx_sop
                    && in_range(cur_byte, pgc_pkg::LC1_FIRST, pgc_pkg::LC1_LAST);
    // (RULE16) window 65..96
    assign hit_65 = half_duplex_i && tx_seen && rx_sop
                    && in_range(cur_byte, pgc_pkg::LC2_FIRST, pgc_pkg::LC2_LAST);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lc_97_q <= 8'h00;
            lc_65_q <= 8'h00;
        end else begin
            // (RULE17) clear on read, saturate, a hit in the read cycle survives
            if (rd_lc) begin
                lc_97_q <= 8'h00;
                lc_65_q <= 8'h00;
            end
            if (hit_97) begin
                lc_97_q <= sat_inc(rd_lc ? 8'h00 : lc_97_q);
            end
            if (hit_65) begin
                lc_65_q <= sat_inc(rd_lc ? 8'h00 : lc_65_q);
            end
        end
    end

endmodule

`default_nettype wire

// ### tb_pgc_top.sv
// Testbench for pgc_top: register tasks, loopback partner, collision stimulus.
// Assumes pgc_pkg, pgc_top, pgc_chk and pgc_partner are compiled first.
`default_nettype none
module tb_pgc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        mac_en = 1'b0;
    logic        hdx = 1'b0;
    logic        loop = 1'b0;
    logic        kick = 1'b0;
    logic [15:0] rdata;
    logic [7:0]  txd;
    logic [7:0]  rxd;
    logic        tx_en, tx_er, rx_dv, rx_er, stub;
    int          n_fail = 0;
    int          comparisons = 0;
    int          cyc = 0;
    initial forever #20 mclk_i = ~mclk_i;
    pgc_top i_pgc_top (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .gen_txd_o(txd), .gen_tx_en_o(tx_en),
        .gen_tx_er_o(tx_er), .mac_tx_en_i(mac_en), .rxd_i(rxd), .rx_dv_i(rx_dv),
        .rx_er_i(rx_er), .half_duplex_i(hdx), .stub_test_o(stub));
    pgc_partner i_pgc_partner (.clk_i(mclk_i), .rst_i(rst_i), .loop_i(loop), .kick_i(kick),
        .txd_i(txd), .tx_en_i(tx_en), .tx_er_i(tx_er), .rxd_o(rxd), .rx_dv_o(rx_dv),
        .rx_er_o(rx_er));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rreg(a, d);
        check($sformatf("reg %h", a), exp, d);
    endtask
    // Polls the done bit; no answer in time counts as a failure
    task automatic wait_done;
        logic [15:0] d;
        d = 16'h0000;
        for (int i = 0; i < 1000 && d[7] !== 1'b1; i++) rreg(5'h10, d);
        check("done", 16'h0001, {15'h0000, d[7]});
    endtask
    // Receive start lands n+3 bytes into a MAC transmission
    task automatic coll(input int n);
        @(posedge mclk_i);
        mac_en <= 1'b1;
        hdx <= 1'b1;
        repeat (n) @(posedge mclk_i);
        kick <= 1'b1;
        @(posedge mclk_i);
        kick <= 1'b0;
        repeat (20) @(posedge mclk_i);
        mac_en <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk(5'h10, 16'h0000);
        rchk(5'h13, 16'h000C);
        rchk(5'h11, 16'h0000);
        rchk(5'h17, 16'h0000);
        rchk(5'h05, 16'h0000);
        loop <= 1'b1;
        wreg(5'h10, 16'h025C);
        rchk(5'h10, 16'h025C);
        wait_done();
        rchk(5'h10, 16'h02DC);
        rchk(5'h11, 16'h0200);
        wreg(5'h10, 16'h02DC);
        rchk(5'h10, 16'h02DC);
        wreg(5'h10, 16'h025C);
        rchk(5'h10, 16'h025C);
        wait_done();
        rchk(5'h11, 16'h0400);
        wreg(5'h10, 16'h0010);
        wreg(5'h10, 16'h011B);
        wait_done();
        rchk(5'h10, 16'h0193);
        rchk(5'h11, 16'h0501);
        wreg(5'h12, 16'h0010);
        rchk(5'h11, 16'h0000);
        wreg(5'h12, 16'h0008);
        rchk(5'h12, 16'h0008);
        check("stub", 16'h0001, {15'h0000, stub});
        loop <= 1'b0;
        coll(79);
        rchk(5'h17, 16'h0001);
        rchk(5'h17, 16'h0000);
        coll(109);
        rchk(5'h17, 16'h0100);
        tally_and_finish();
    end
endmodule
bind pgc_top pgc_chk #(.PRE_BYTES(PRE_BYTES)) i_pgc_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gen_txd_o(gen_txd_o),
    .gen_tx_en_o(gen_tx_en_o), .gen_tx_er_o(gen_tx_er_o), .stub_test_o(stub_test_o));
`default_nettype wire
